// *** hdl/lmis_core.v ***
/*
 * Legacy-mode instruction semantics helper of the core execute path:
 * barrier flush, program-counter store value, block-store base value,
 * undefined-form detection, legacy PC masking and status-updating forms.
 * Assumes one clock, a synchronous active-low reset, decode inputs from
 * logic on the same clock and a plain register port from software.
 */
// Behaviour
// - Barrier discards all retained instruction-stream state.
// - Base lowest in store list stores original.
// - Base not lowest stores unspecified value.
// - Stored program counter is instruction address plus 8.
// - Register-shift with PC operand is undefined.
// - Legacy modes hold top six PC bits zero.
// - Compare/test with destination 1111 is alternate form.
// - Alternate form computes result, suppresses normal flags.
// - Result bits copied to flags; masks, low two mode bits outside user mode.
// - Alternate form takes three cycles plus shift extras.
// - Legacy flag-setting write to PC updates status.
// - Legacy block load of PC with status updates.
`timescale 1ns/1ps
`include "lmis_regs.vh"
module lmis_core (
    input  wire        clk,
    input  wire        nrst,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        ex_valid,
    output wire        ex_ready,
    input  wire [31:0] ex_instr,
    input  wire [31:0] ex_pc,
    input  wire [31:0] ex_op1,
    input  wire [31:0] ex_op2,
    input  wire [31:0] ex_result,
    input  wire [1:0]  ex_shift_extra,
    input  wire        ld_pc_valid,
    input  wire [31:0] ld_pc_data,
    input  wire        st_valid,
    input  wire [31:0] st_instr_pc,
    input  wire [3:0]  st_reg_idx,
    input  wire [31:0] st_reg_val,
    input  wire        st_block,
    input  wire        st_wb,
    input  wire [3:0]  st_base_idx,
    input  wire [15:0] st_list,
    input  wire [31:0] st_base_orig,
    output reg  [31:0] st_data,
    output reg         st_data_valid,
    input  wire [31:0] fetch_pc,
    output reg  [31:0] fetch_addr,
    output reg         flush,
    output reg         undef,
    output reg         pred_valid,
    input  wire        pred_load,
    output reg  [31:0] status_word,
    output wire        legacy_mode
);

////////////////////////////////////////////////////////////////////////////////
// Decode helpers

function is_dp;
    input [31:0] w;
    begin
        is_dp = (w[27:26] == 2'h0) && !(w[25] == 1'b0 && w[7] == 1'b1 && w[4] == 1'b1);
    end
endfunction

function is_cmp_op;
    input [31:0] w;
    begin
        is_cmp_op = is_dp(w) && (w[24:23] == 2'h2);
    end
endfunction

function is_reg_shift;
    input [31:0] w;
    begin
        is_reg_shift = is_dp(w) && !w[`LMIS_F_IMM] && w[`LMIS_F_REGSHIFT];
    end
endfunction

// Index of the lowest set bit of a register list
function [3:0] lowest_reg;
    input [15:0] list;
    integer i;
    begin
        lowest_reg = 4'hF;
        for (i = 15; i >= 0; i = i - 1) begin
            if (list[i]) begin
                lowest_reg = i[3:0];
            end
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Instruction classification

wire        user_any;
wire        take;
wire        dec_barrier;
wire        dec_alt;
wire        dec_dp_pc_s;
wire        dec_ldm_pc_s;
wire        dec_undef;
wire [2:0]  alt_cycles;

assign legacy_mode = !status_word[`LMIS_ST_MODE4];
assign user_any    = status_word[3:0] == `LMIS_MODE_USER_LOW;
assign take        = ex_valid && ex_ready;

assign dec_barrier = (ex_instr[27:24] == 4'hF) && (ex_instr[23:0] == `LMIS_IMB_CODE);

// Alternate form in every mode, keyed on destination field 1111
assign dec_alt = is_cmp_op(ex_instr) && ex_instr[`LMIS_F_SBIT]
               && (ex_instr[15:12] == 4'hF);

assign dec_dp_pc_s = is_dp(ex_instr) && !is_cmp_op(ex_instr)
                   && ex_instr[`LMIS_F_SBIT] && (ex_instr[15:12] == 4'hF);

assign dec_ldm_pc_s = (ex_instr[27:25] == 3'h4) && ex_instr[`LMIS_F_LBIT]
                    && ex_instr[`LMIS_F_PSR_BIT] && ex_instr[15];

// Register shift with the PC as a main operand, or a coprocessor
// register transfer sourced from the PC
assign dec_undef = (is_reg_shift(ex_instr)
                    && (ex_instr[19:16] == 4'hF || ex_instr[3:0] == 4'hF))
                 || (ex_instr[27:24] == 4'hE && !ex_instr[`LMIS_F_LBIT]
                     && ex_instr[4] && ex_instr[15:12] == 4'hF);

// Base count less one, since the issue cycle is the first
assign alt_cycles = `LMIS_ALT_BASE_CYC - 3'h1 + {1'b0, ex_shift_extra}
                  + {2'h0, is_reg_shift(ex_instr)};

////////////////////////////////////////////////////////////////////////////////
// Control register and barrier counter

reg         trap_en;
reg [15:0]  barrier_cnt;
reg [2:0]   alt_cnt;
reg         ldm_pending;

always @(posedge clk) begin
    if (!nrst) begin
        trap_en <= `LMIS_CTRL_RST;
    end else if (reg_wr && reg_addr == `LMIS_CTRL_OFS) begin
        trap_en <= reg_wdata[0];
    end
end

always @(posedge clk) begin
    if (!nrst) begin
        barrier_cnt <= `LMIS_BCNT_RST;
    end else if (take && dec_barrier) begin
        barrier_cnt <= barrier_cnt + 16'h0001;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Barrier flush of retained instruction-stream state

always @(posedge clk) begin
    if (!nrst) begin
        flush      <= 1'b0;
        pred_valid <= 1'b0;
    end else begin
        flush <= take && dec_barrier;
        // Clear wins over a prediction arriving in the same cycle
        if (take && dec_barrier) begin
            pred_valid <= 1'b0;
        end else if (pred_load) begin
            pred_valid <= 1'b1;
        end
    end
end

// Fetch stalls while the barrier is flushing
assign ex_ready = (alt_cnt == 3'h0) && !flush;

////////////////////////////////////////////////////////////////////////////////
// Legacy program-counter masking

always @(posedge clk) begin
    if (!nrst) begin
        fetch_addr <= 32'h00000000;
    end else if (legacy_mode) begin
        fetch_addr <= {{`LMIS_LEGACY_TOP{1'b0}}, fetch_pc[25:0]};
    end else begin
        fetch_addr <= fetch_pc;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Store data: program counter and block-store base

wire [31:0] pc_plus8;
wire [31:0] pc_store;

assign pc_plus8 = st_instr_pc + `LMIS_PC_STORE_OFS;
// Wrap past the legacy top is left to software
assign pc_store = legacy_mode
                ? {{`LMIS_LEGACY_TOP{1'b0}}, pc_plus8[25:0]}
                : pc_plus8;

always @(posedge clk) begin
    if (!nrst) begin
        st_data       <= 32'h00000000;
        st_data_valid <= 1'b0;
    end else begin
        st_data_valid <= st_valid;
        if (st_valid) begin
            if (st_reg_idx == 4'hF) begin
                st_data <= pc_store;
            end else if (st_block && st_wb && st_reg_idx == st_base_idx
                         && lowest_reg(st_list) == st_base_idx) begin
                st_data <= st_base_orig;
            end else begin
                // Base not lowest: whatever the register holds
                st_data <= st_reg_val;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Undefined-form reporting

always @(posedge clk) begin
    if (!nrst) begin
        undef <= 1'b0;
    end else begin
        undef <= take && dec_undef && trap_en;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Status-updating forms

wire [31:0] alt_result;
wire [31:0] upd_src;
wire [31:0] upd_status;
wire        alt_done;
wire        dp_upd;
wire        ldm_upd;

lmis_alu u_alu (
    .clk    (clk),
    .nrst   (nrst),
    .load   (take && dec_alt),
    .op     (ex_instr[22:21]),
    .op_a   (ex_op1),
    .op_b   (ex_op2),
    .result (alt_result)
);

assign alt_done = alt_cnt == 3'h1;
assign dp_upd   = take && dec_dp_pc_s && legacy_mode;
assign ldm_upd  = ld_pc_valid && ldm_pending;

assign upd_src = alt_done ? alt_result : (dp_upd ? ex_result : ld_pc_data);

lmis_stupd u_stupd (
    .cur_status (status_word),
    .value      (upd_src),
    .user_mode  (user_any),
    .new_status (upd_status)
);

always @(posedge clk) begin
    if (!nrst) begin
        alt_cnt <= 3'h0;
    end else if (take && dec_alt) begin
        alt_cnt <= alt_cycles;
    end else if (alt_cnt != 3'h0) begin
        alt_cnt <= alt_cnt - 3'h1;
    end
end

// Legacy block load of the PC with status: wait for the loaded word
always @(posedge clk) begin
    if (!nrst) begin
        ldm_pending <= 1'b0;
    end else if (take && dec_ldm_pc_s && legacy_mode) begin
        ldm_pending <= 1'b1;
    end else if (ld_pc_valid) begin
        ldm_pending <= 1'b0;
    end
end

// Hardware updates win over a software write in the same cycle
always @(posedge clk) begin
    if (!nrst) begin
        status_word <= `LMIS_STAT_RST;
    end else if (alt_done || dp_upd || ldm_upd) begin
        status_word <= upd_status;
    end else if (reg_wr && reg_addr == `LMIS_STAT_OFS) begin
        // Mode-set switches must be fenced by a barrier in software
        status_word <= reg_wdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Register read port

always @(posedge clk) begin
    if (!nrst) begin
        reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
        case (reg_addr)
            `LMIS_CTRL_OFS: reg_rdata <= {31'h00000000, trap_en};
            `LMIS_STAT_OFS: reg_rdata <= status_word;
            `LMIS_BCNT_OFS: reg_rdata <= {16'h0000, barrier_cnt};
            default:        reg_rdata <= 32'h00000000;
        endcase
    end else begin
        reg_rdata <= 32'h00000000;
    end
end

endmodule // lmis_core

// *** hdl/lmis_regs.vh ***
/*
 * Constants of the legacy-mode execution helper: register offsets,
 * reset values, field positions and cycle counts.
 * Assumes inclusion by bare name from the helper's design files.
 */
`ifndef LMIS_REGS_VH
`define LMIS_REGS_VH

// Register offsets (byte addresses on the plain register port)
`define LMIS_CTRL_OFS       4'h0
`define LMIS_STAT_OFS       4'h4
`define LMIS_BCNT_OFS       4'h8

// Reset values
`define LMIS_CTRL_RST       1'h1
`define LMIS_STAT_RST       32'h000000D3
`define LMIS_BCNT_RST       16'h0000

// Status word field positions
`define LMIS_ST_MODE4       4
`define LMIS_ST_IRQ_MASK    7
`define LMIS_ST_FIQ_MASK    6
// User mode in either mode set: low four mode bits all zero
`define LMIS_MODE_USER_LOW  4'h0

// Instruction field positions
`define LMIS_F_SBIT         20
`define LMIS_F_LBIT         20
`define LMIS_F_PSR_BIT      22
`define LMIS_F_REGSHIFT     4
`define LMIS_F_IMM          25

// Program counter store offset and count of legacy top bits held zero
`define LMIS_PC_STORE_OFS   32'h00000008
`define LMIS_LEGACY_TOP     6

// Alternate compare/test form base cycle count
`define LMIS_ALT_BASE_CYC   3'h3

// Barrier encoding: comment field of a software-trap word
`define LMIS_IMB_CODE       24'hF00000

`endif

// *** hdl/lmis_alu.v ***
/*
 * Result unit of the alternate compare/test form: sum, difference,
 * exclusive-or or and-result of two operands, held in a register.
 * Assumes the caller pulses load with the operands valid.
 */
`timescale 1ns/1ps
module lmis_alu (
    input  wire        clk,
    input  wire        nrst,
    input  wire        load,
    input  wire [1:0]  op,
    input  wire [31:0] op_a,
    input  wire [31:0] op_b,
    output reg  [31:0] result
);

reg [31:0] next_result;

always @* begin
    case (op)
        2'h0:    next_result = op_a & op_b;   // test_bits_status_form
        2'h1:    next_result = op_a ^ op_b;   // test_equivalence_status_form
        2'h2:    next_result = op_a - op_b;   // compare_status_form
        2'h3:    next_result = op_a + op_b;   // compare_negative_status_form
        default: next_result = 32'h00000000;
    endcase
end

always @(posedge clk) begin
    if (!nrst) begin
        result <= 32'h00000000;
    end else if (load) begin
        result <= next_result;
    end
end

endmodule // lmis_alu

// *** hdl/lmis_stupd.v ***
/*
 * Status-word update mapper for legacy status-updating forms.
 * Assumes cur_status is the current status word and value the word
 * whose bits are copied; purely combinational.
 */
`timescale 1ns/1ps
`include "lmis_regs.vh"
module lmis_stupd (
    input  wire [31:0] cur_status,
    input  wire [31:0] value,
    input  wire        user_mode,
    output reg  [31:0] new_status
);

always @* begin
    new_status = cur_status;
    new_status[31:28] = value[31:28];
    if (!user_mode) begin
        new_status[`LMIS_ST_IRQ_MASK] = value[27];
        new_status[`LMIS_ST_FIQ_MASK] = value[26];
        new_status[1:0] = value[1:0];
    end
end

endmodule // lmis_stupd

// *** verif/lmis_core_props.sv ***
/* Port checker of the legacy-mode execution helper.
   Assumes binding onto lmis_core; one clock, synchronous low reset. */
`timescale 1ns/1ps
`include "lmis_regs.vh"
module lmis_core_props (
    input wire        clk,
    input wire        nrst,
    input wire        ex_valid,
    input wire        ex_ready,
    input wire [31:0] ex_instr,
    input wire [1:0]  ex_shift_extra,
    input wire        st_valid,
    input wire [31:0] st_instr_pc,
    input wire [3:0]  st_reg_idx,
    input wire        st_block,
    input wire        st_wb,
    input wire [3:0]  st_base_idx,
    input wire [15:0] st_list,
    input wire [31:0] st_base_orig,
    input wire [31:0] st_data,
    input wire [31:0] fetch_pc,
    input wire [31:0] fetch_addr,
    input wire        flush,
    input wire        pred_valid,
    input wire [31:0] status_word,
    input wire        legacy_mode
);
    // First edge after release still sees reset-time outputs
    reg live;
    always @(posedge clk) begin
        live <= nrst;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst || !live);
    ////////////////////////////////////////////////////////////////////////
    wire acc = ex_valid && ex_ready;
    wire instruction_memory_barrier = acc && ex_instr[27:24] == 4'hF && ex_instr[23:0] == `LMIS_IMB_CODE;
    // Only the plain-shift case; extra shift cycles would move the bound
    wire alt = acc && ex_instr[27:26] == 2'h0 && ex_instr[24:23] == 2'h2 && ex_instr[20]
               && ex_instr[15:12] == 4'hF && !ex_instr[25] && !ex_instr[4]
               && ex_shift_extra == 2'h0;
    wire low = st_list[st_base_idx] && (st_list & ((16'h1 << st_base_idx) - 16'h1)) == 16'h0;
    ////////////////////////////////////////////////////////////////////////
    flush_pulse_a: assert property (instruction_memory_barrier |=> flush)
        else $error("barrier gave no flush");
    pred_clear_a: assert property (instruction_memory_barrier |=> !pred_valid)
        else $error("prediction kept over barrier");
    flush_stall_a: assert property (instruction_memory_barrier |=> !ex_ready)
        else $error("fetch not held during flush");
    alt_wait_a: assert property (alt |=> !ex_ready [*2] ##1 ex_ready)
        else $error("alternate form length wrong");
    alt_user_a: assert property (alt && status_word[3:0] == 4'h0 |->
        ##3 status_word[27:0] == $past(status_word[27:0], 3))
        else $error("user alternate form touched control bits");
    store_pc_a: assert property (st_valid && st_reg_idx == 4'hF && !legacy_mode |=>
        st_data == $past(st_instr_pc) + `LMIS_PC_STORE_OFS)
        else $error("stored pc offset wrong");
    base_orig_a: assert property (st_valid && st_block && st_wb
        && st_reg_idx == st_base_idx && low |=> st_data == $past(st_base_orig))
        else $error("lowest base not original");
    fetch_mask_a: assert property (legacy_mode |=> fetch_addr[31:26] == 6'h00)
        else $error("legacy fetch top bits set");
    fetch_full_a: assert property (!legacy_mode |=> fetch_addr == $past(fetch_pc))
        else $error("full fetch address altered");
endmodule // lmis_core_props

bind lmis_core lmis_core_props u_props (.clk(clk), .nrst(nrst), .ex_valid(ex_valid),
    .ex_ready(ex_ready), .ex_instr(ex_instr), .ex_shift_extra(ex_shift_extra),
    .st_valid(st_valid), .st_instr_pc(st_instr_pc), .st_reg_idx(st_reg_idx),
    .st_block(st_block), .st_wb(st_wb), .st_base_idx(st_base_idx), .st_list(st_list),
    .st_base_orig(st_base_orig), .st_data(st_data), .fetch_pc(fetch_pc),
    .fetch_addr(fetch_addr), .flush(flush), .pred_valid(pred_valid),
    .status_word(status_word), .legacy_mode(legacy_mode));

// *** verif/lmis_core_tb.sv ***
/* Self-checking bench of the legacy-mode helper.
   Assumes the checker file is compiled with the design. */
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module lmis_core_tb;
    logic        clk, nrst, reg_wr, reg_rd, ex_valid, ld_pc_valid, st_valid, st_block, pred_load;
    logic [3:0]  reg_addr, st_reg_idx;
    logic [1:0]  ex_shift_extra;
    logic [31:0] reg_wdata, ex_instr, ex_pc, ex_op1, ex_op2, ld_pc_data, st_reg_val, s, r;
    logic [31:0] fetch_pc;
    logic [15:0] st_list;
    wire  [31:0] reg_rdata, st_data, fetch_addr, status_word;
    wire         ex_ready, st_data_valid, flush, undef, pred_valid, legacy_mode;
    int          fails, compares, k;
    localparam [31:0] A = 32'h9C000002;
    localparam [31:0] B = 32'h64000003;
    ////////////////////////////////////////////////////////////////////////
    lmis_core dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ex_valid(ex_valid),
        .ex_ready(ex_ready), .ex_instr(ex_instr), .ex_pc(ex_pc), .ex_op1(ex_op1),
        .ex_op2(ex_op2), .ex_result(ex_op1), .ex_shift_extra(ex_shift_extra),
        .ld_pc_valid(ld_pc_valid), .ld_pc_data(ld_pc_data), .st_valid(st_valid),
        .st_instr_pc(32'hFC001000), .st_reg_idx(st_reg_idx), .st_reg_val(st_reg_val),
        .st_block(st_block), .st_wb(st_block), .st_base_idx(4'h3), .st_list(st_list),
        .st_base_orig(32'h22222222), .st_data(st_data), .st_data_valid(st_data_valid),
        .fetch_pc(fetch_pc), .fetch_addr(fetch_addr), .flush(flush), .undef(undef),
        .pred_valid(pred_valid), .pred_load(pred_load), .status_word(status_word),
        .legacy_mode(legacy_mode));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task wr(input [3:0] a, input [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task rd(input [3:0] a, input [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    // Operand one doubles as the core result for the r15 write form
    task exe(input [31:0] i, input [31:0] a, input [31:0] b);
        @(posedge clk);
        ex_instr <= i;
        ex_op1   <= a;
        ex_op2   <= b;
        ex_pc    <= b;
        ex_valid <= 1'b1;
        @(posedge clk);
        // Hold the offer until the block takes it
        while (!ex_ready) begin
            @(posedge clk);
        end
        ex_valid <= 1'b0;
        #1;
    endtask
    task st(input b, input [3:0] i, input [15:0] l, input [31:0] e);
        @(posedge clk);
        st_valid   <= 1'b1;
        st_block   <= b;
        st_reg_idx <= i;
        st_list    <= l;
        st_reg_val <= ~e;
        @(posedge clk);
        st_valid   <= 1'b0;
        #1 `CHK(st_data_valid, 1'b1)
        `CHK(st_data, e)
    endtask
    function automatic [31:0] upd(input [31:0] v, input [31:0] x);
        upd = (v[3:0] == 4'h0) ? {x[31:28], v[27:0]}
                               : {x[31:28], v[27:8], x[27:26], v[5:2], x[1:0]};
    endfunction
    // Test, test-equivalence, compare, compare-negative in turn
    task alt_all;
        for (k = 0; k < 4; k++) begin
            r = (k == 0) ? (A & B) : (k == 1) ? (A ^ B) : (k == 2) ? (A - B) : (A + B);
            exe(32'hE110F000 + (32'(k) << 21), A, B);
            `CHK(ex_ready, 1'b0)
            repeat (2) @(posedge clk);
            #1 s = upd(s, r);
            `CHK(ex_ready, 1'b1)
            `CHK(status_word, s)
        end
    endtask
    task report_and_stop;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        report_and_stop;
    end
    initial begin
        {nrst, reg_wr, reg_rd, ex_valid, ld_pc_valid, st_valid, st_block, pred_load} = 8'h00;
        {reg_addr, st_reg_idx, st_list} = 24'h000000;
        {reg_wdata, ex_instr, ex_pc, ex_op1, ex_op2, ld_pc_data, st_reg_val} = 224'h0;
        fetch_pc = 32'hFFFFFFFC;
        ex_shift_extra = 2'h0;
        fails = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(4'h0, 32'h00000001);
        rd(4'h4, 32'h000000D3);
        wr(4'h8, 32'h00000005);
        rd(4'h8, 32'h00000000);
        rd(4'hC, 32'h00000000);
        `CHK(fetch_addr, 32'hFFFFFFFC)
        s = 32'h000000D3;
        alt_all;
        // Register-specified shift plus one extra cycle stretches the form
        @(posedge clk);
        ex_shift_extra <= 2'h1;
        exe(32'hE110F110, A, B);
        repeat (3) @(posedge clk);
        #1 `CHK(ex_ready, 1'b0)
        `CHK(status_word, s)
        @(posedge clk);
        ex_shift_extra <= 2'h0;
        #1 s = upd(s, A & B);
        `CHK(ex_ready, 1'b1)
        `CHK(status_word, s)
        @(posedge clk);
        pred_load <= 1'b1;
        @(posedge clk);
        pred_load <= 1'b0;
        #1 `CHK(pred_valid, 1'b1)
        exe(32'hEFF00000, 32'h0, 32'h0);
        `CHK({flush, pred_valid, ex_ready}, 3'h4)
        rd(4'h8, 32'h00000001);
        exe(32'hE08F0211, 32'h0, 32'h0);
        `CHK(undef, 1'b1)
        wr(4'h0, 32'h00000000);
        exe(32'hE08F0211, 32'h0, 32'h0);
        `CHK(undef, 1'b0)
        st(1'b0, 4'hF, 16'h0000, 32'hFC001008);
        st(1'b1, 4'h3, 16'h8028, 32'h22222222);
        st(1'b1, 4'hF, 16'h8028, 32'hFC001008);
        // Supervisor legacy mode: entered inside the space, fenced by a barrier
        @(posedge clk);
        fetch_pc <= 32'h00001000;
        s = 32'h000000C3;
        wr(4'h4, s);
        exe(32'hEFF00000, 32'h0, 32'h0);
        `CHK(legacy_mode, 1'b1)
        `CHK(fetch_addr, 32'h00001000)
        // Junk top bits, never stepping across the wrap
        @(posedge clk);
        fetch_pc <= 32'hFC002000;
        @(posedge clk);
        #1 `CHK(fetch_addr, 32'h00002000)
        st(1'b0, 4'hF, 16'h0000, 32'h00001008);
        // User legacy mode: flags only
        s = 32'h00000000;
        wr(4'h4, s);
        alt_all;
        exe(32'hE1B0F00E, 32'h50000000, 32'h0);
        repeat (2) @(posedge clk);
        #1 s = upd(s, 32'h50000000);
        `CHK(status_word, s)
        exe(32'hE8D08000, 32'h0, 32'h0);
        @(posedge clk);
        ld_pc_valid <= 1'b1;
        ld_pc_data  <= 32'hA0000000;
        @(posedge clk);
        ld_pc_valid <= 1'b0;
        #1 s = upd(s, 32'hA0000000);
        `CHK(status_word, s)
        report_and_stop;
    end
endmodule // lmis_core_tb
